// ### shared/pcfg_pkg.sv
package pcfg_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] CMD_STATUS_OFS = 16'hD004;
	localparam logic [15:0] CLASS_REV_OFS = 16'hD008;
	localparam logic [15:0] HDR_LAT_OFS = 16'hD00C;
	localparam logic [15:0] INIT_LOAD_OFS = 16'hD000;

	// ****************************************
	// Command field positions
	// ****************************************
	localparam int IO_TGT_BIT = 0;
	localparam int MEM_TGT_BIT = 1;
	localparam int INIT_EN_BIT = 2;
	localparam int SPEC_CYC_BIT = 3;
	localparam int WINV_BIT = 4;
	localparam int PAL_SNOOP_BIT = 5;

	// ****************************************
	// Header / latency / cache line / class code fields
	// ****************************************
	localparam int SELF_TEST_BIT = 31;
	localparam int MULTI_FN_BIT = 23;
	localparam int HDR_TYPE_LSB = 16;
	localparam int LAT_LSB = 8;
	localparam int LINE_LSB = 0;
	localparam int CLASS_LSB = 8;

	// ****************************************
	// Reset values and latency write mask
	// ****************************************
	localparam logic [23:0] CLASS_RST = 24'h060000;
	// Arbitrary neutral revision value
	localparam logic [7:0] REV_RST = 8'h01;
	localparam logic [6:0] HDR_TYPE_RST = 7'h00;
	localparam logic [7:0] LAT_RST = 8'h00;
	localparam logic [7:0] LINE_RST = 8'h00;
	localparam logic [7:0] LAT_MASK = 8'hFC;

	// ****************************************
	// Bus answers
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [23:0] class_code;
		logic [7:0] revision;
		logic [6:0] header_type;
	} pcfg_ident_t;

	typedef struct packed {
		logic write_invalidate_enable;
		logic initiator_enable;
		logic memory_target_enable;
		logic io_target_enable;
		logic [7:0] latency_count;
		logic [7:0] line_size_field;
	} pcfg_ctrl_t;

	typedef enum logic [1:0] {
		PCFG_R_IDLE = 2'b00,
		PCFG_R_DATA = 2'b01
	} pcfg_rd_state_t;

	typedef enum logic [1:0] {
		PCFG_W_IDLE = 2'b00,
		PCFG_W_RESP = 2'b01
	} pcfg_wr_state_t;
endpackage : pcfg_pkg

// ### verilog/pcfg_ident.sv
// Holds class code, revision and header type; loadable during initialisation
module pcfg_ident
	import pcfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic load_en,
	input wire pcfg_ident_t load_val,
	output pcfg_ident_t ident
);
	always_ff @(posedge clk) begin
		if (rst) begin
			ident.class_code <= CLASS_RST;
			ident.revision <= REV_RST;
			ident.header_type <= HDR_TYPE_RST;
		end else if (load_en) begin
			ident <= load_val;
		end
	end

	property p_load_takes;
		@(posedge clk) disable iff (rst)
		load_en |=> ident == $past(load_val);
	endproperty
	a_load_takes: assert property (p_load_takes)
		else $error("Identity load not taken");

	property p_ident_holds;
		@(posedge clk) disable iff (rst)
		!load_en |=> $stable(ident);
	endproperty
	a_ident_holds: assert property (p_ident_holds)
		else $error("Identity changed without load");
endmodule : pcfg_ident

// ### verilog/pcfg_regs.sv
module pcfg_regs
	import pcfg_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic BOOT_MODE,
	input wire logic HOST_MODE,
	input wire logic SATELLITE_MODE,
	input wire logic INIT_LOAD,
	input wire logic [23:0] INIT_CLASS,
	input wire logic [7:0] INIT_REV,
	input wire logic [6:0] INIT_HDR_TYPE,
	input wire logic TGT_MEM_HIT,
	input wire logic TGT_IO_HIT,
	input wire logic TGT_SPECIAL_CYCLE,
	input wire logic MST_WRITE_REQ,
	input wire logic MST_BURST_READ_REQ,
	input wire logic MST_GNT_LOST,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic CLAIM_MEM,
	output logic CLAIM_IO,
	output logic INITIATOR_ALLOWED,
	output logic USE_MWI,
	output logic BURST_READ_LINE,
	output logic LAT_EXPIRED
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic [15:0] word_ofs(input logic [31:0] addr);
		return {addr[15:2], 2'b00};
	endfunction : word_ofs

	// ****************************************
	// State
	// ****************************************
	pcfg_ctrl_t ctrl_r;
	pcfg_ident_t ident;
	pcfg_ident_t load_val;
	pcfg_rd_state_t rd_state_r;
	pcfg_wr_state_t wr_state_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r;
	logic w_have_r;
	logic [31:0] cmd_word;
	logic [31:0] ccrev_word;
	logic [31:0] hdr_word;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_fire;
	logic [15:0] wofs;
	logic [31:0] merged;
	logic [7:0] lat_cnt_r;
	logic boot_host_r;
	logic rst_d_r;

	assign load_val = '{class_code: INIT_CLASS, revision: INIT_REV,
		header_type: INIT_HDR_TYPE};

	pcfg_ident u_ident (
		.clk(REF_CLK),
		.rst(RESET),
		.load_en(INIT_LOAD),
		.load_val(load_val),
		.ident(ident)
	);

	// ****************************************
	// Read views
	// ****************************************
	always_comb begin
		cmd_word = 32'h0000_0000;
		cmd_word[IO_TGT_BIT] = ctrl_r.io_target_enable;
		cmd_word[MEM_TGT_BIT] = ctrl_r.memory_target_enable;
		cmd_word[INIT_EN_BIT] = ctrl_r.initiator_enable;
		cmd_word[SPEC_CYC_BIT] = 1'b0;
		cmd_word[WINV_BIT] = ctrl_r.write_invalidate_enable;
		cmd_word[PAL_SNOOP_BIT] = 1'b0;
		ccrev_word = {ident.class_code, ident.revision};
		hdr_word = 32'h0000_0000;
		hdr_word[SELF_TEST_BIT] = 1'b0;
		hdr_word[MULTI_FN_BIT] = 1'b0;
		hdr_word[HDR_TYPE_LSB +: 7] = ident.header_type;
		hdr_word[LAT_LSB +: 8] = ctrl_r.latency_count;
		hdr_word[LINE_LSB +: 8] = ctrl_r.line_size_field;
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (word_ofs(S_AXI_ARADDR) == CMD_STATUS_OFS) begin
			rd_word = cmd_word;
		end else if (word_ofs(S_AXI_ARADDR) == CLASS_REV_OFS && !SATELLITE_MODE) begin
			rd_word = ccrev_word;
		end else if (word_ofs(S_AXI_ARADDR) == HDR_LAT_OFS) begin
			rd_word = hdr_word;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rd_state_r <= PCFG_R_IDLE;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			case (rd_state_r)
				PCFG_R_IDLE: begin
					if (S_AXI_ARVALID && !S_AXI_ARREADY) begin
						S_AXI_ARREADY <= 1'b1;
						S_AXI_RVALID <= 1'b1;
						S_AXI_RDATA <= rd_word;
						S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
						rd_state_r <= PCFG_R_DATA;
					end
				end
				PCFG_R_DATA: begin
					S_AXI_ARREADY <= 1'b0;
					if (S_AXI_RREADY) begin
						S_AXI_RVALID <= 1'b0;
						rd_state_r <= PCFG_R_IDLE;
					end
				end
				default: rd_state_r <= PCFG_R_IDLE;
			endcase
		end
	end

	// ****************************************
	// Write channel
	// ****************************************
	// Address and data are latched separately, so either may come first
	assign wr_fire = aw_have_r && w_have_r && wr_state_r == PCFG_W_IDLE;
	assign wofs = word_ofs(awaddr_r);

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			if (S_AXI_AWVALID && !aw_have_r && !S_AXI_AWREADY) begin
				S_AXI_AWREADY <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
				aw_have_r <= 1'b1;
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
			if (S_AXI_WVALID && !w_have_r && !S_AXI_WREADY) begin
				S_AXI_WREADY <= 1'b1;
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
				w_have_r <= 1'b1;
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wr_state_r <= PCFG_W_IDLE;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			case (wr_state_r)
				PCFG_W_IDLE: begin
					if (wr_fire) begin
						S_AXI_BVALID <= 1'b1;
						wr_state_r <= PCFG_W_RESP;
						if (wofs == CMD_STATUS_OFS || wofs == HDR_LAT_OFS) begin
							S_AXI_BRESP <= RESP_OKAY;
						end else if (wofs == CLASS_REV_OFS && !SATELLITE_MODE) begin
							S_AXI_BRESP <= RESP_OKAY;
						end else begin
							S_AXI_BRESP <= RESP_SLVERR;
						end
					end
				end
				PCFG_W_RESP: begin
					if (S_AXI_BREADY) begin
						S_AXI_BVALID <= 1'b0;
						wr_state_r <= PCFG_W_IDLE;
					end
				end
				default: wr_state_r <= PCFG_W_IDLE;
			endcase
		end
	end

	// ****************************************
	// Control fields
	// ****************************************
	// Mode straps are caught one cycle after reset release
	always_ff @(posedge REF_CLK) begin
		boot_host_r <= BOOT_MODE && HOST_MODE;
		rst_d_r <= RESET;
	end

	assign merged = (wofs == CMD_STATUS_OFS) ? merge_bytes(cmd_word, wdata_r, wstrb_r)
		: merge_bytes(hdr_word, wdata_r, wstrb_r);

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctrl_r.write_invalidate_enable <= 1'b0;
			ctrl_r.initiator_enable <= 1'b0;
			ctrl_r.memory_target_enable <= 1'b0;
			ctrl_r.io_target_enable <= 1'b0;
			ctrl_r.latency_count <= LAT_RST;
			ctrl_r.line_size_field <= LINE_RST;
		end else if (rst_d_r) begin
			ctrl_r.initiator_enable <= BOOT_MODE && HOST_MODE;
		end else if (wr_fire && wofs == CMD_STATUS_OFS) begin
			ctrl_r.io_target_enable <= merged[IO_TGT_BIT];
			ctrl_r.memory_target_enable <= merged[MEM_TGT_BIT];
			ctrl_r.initiator_enable <= merged[INIT_EN_BIT];
			ctrl_r.write_invalidate_enable <= merged[WINV_BIT];
		end else if (wr_fire && wofs == HDR_LAT_OFS) begin
			ctrl_r.latency_count <= merged[LAT_LSB +: 8] & LAT_MASK;
			ctrl_r.line_size_field <= merged[LINE_LSB +: 8];
		end
	end

	// ****************************************
	// Controller-facing outputs
	// ****************************************
	// Latency count runs only while a grant is lost; zero ends at once
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			CLAIM_MEM <= 1'b0;
			CLAIM_IO <= 1'b0;
			INITIATOR_ALLOWED <= 1'b0;
			USE_MWI <= 1'b0;
			BURST_READ_LINE <= 1'b0;
			LAT_EXPIRED <= 1'b0;
			lat_cnt_r <= 8'h00;
		end else begin
			CLAIM_MEM <= TGT_MEM_HIT && !TGT_SPECIAL_CYCLE && ctrl_r.memory_target_enable;
			CLAIM_IO <= TGT_IO_HIT && !TGT_SPECIAL_CYCLE && ctrl_r.io_target_enable;
			INITIATOR_ALLOWED <= ctrl_r.initiator_enable;
			USE_MWI <= MST_WRITE_REQ && ctrl_r.initiator_enable
				&& ctrl_r.write_invalidate_enable;
			BURST_READ_LINE <= MST_BURST_READ_REQ && ctrl_r.line_size_field != 8'h00;
			if (!MST_GNT_LOST) begin
				lat_cnt_r <= 8'h00;
				LAT_EXPIRED <= 1'b0;
			end else if (lat_cnt_r >= ctrl_r.latency_count) begin
				LAT_EXPIRED <= 1'b1;
			end else begin
				lat_cnt_r <= lat_cnt_r + 8'h01;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_mem_gate;
		@(posedge REF_CLK) disable iff (RESET)
		!ctrl_r.memory_target_enable |=> !CLAIM_MEM;
	endproperty
	a_mem_gate: assert property (p_mem_gate)
		else $error("Memory claimed while disabled");

	property p_io_gate;
		@(posedge REF_CLK) disable iff (RESET)
		(TGT_IO_HIT && ctrl_r.io_target_enable && !TGT_SPECIAL_CYCLE) |=> CLAIM_IO;
	endproperty
	a_io_gate: assert property (p_io_gate)
		else $error("Enabled I/O access not claimed");

	property p_no_special;
		@(posedge REF_CLK) disable iff (RESET)
		TGT_SPECIAL_CYCLE |=> !CLAIM_MEM && !CLAIM_IO;
	endproperty
	a_no_special: assert property (p_no_special)
		else $error("Special cycle accepted");

	property p_mwi;
		@(posedge REF_CLK) disable iff (RESET)
		USE_MWI |-> $past(ctrl_r.write_invalidate_enable) && $past(MST_WRITE_REQ);
	endproperty
	a_mwi: assert property (p_mwi)
		else $error("MWI used while disabled");

	property p_lat_low_zero;
		@(posedge REF_CLK) disable iff (RESET)
		ctrl_r.latency_count[1:0] == 2'b00;
	endproperty
	a_lat_low_zero: assert property (p_lat_low_zero)
		else $error("Latency low bits not zero");

	property p_lat_expire;
		@(posedge REF_CLK) disable iff (RESET)
		LAT_EXPIRED |-> $past(MST_GNT_LOST) && lat_cnt_r == ctrl_r.latency_count;
	endproperty
	a_lat_expire: assert property (p_lat_expire)
		else $error("Latency expiry at wrong count");

	property p_fixed_zero;
		@(posedge REF_CLK) disable iff (RESET)
		!cmd_word[SPEC_CYC_BIT] && !cmd_word[PAL_SNOOP_BIT] && !hdr_word[SELF_TEST_BIT]
			&& !hdr_word[MULTI_FN_BIT] && hdr_word[30:24] == 7'h00;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero)
		else $error("Fixed bit reads nonzero");

	property p_satellite_block;
		@(posedge REF_CLK) disable iff (RESET)
		(rd_state_r == PCFG_R_IDLE && S_AXI_ARVALID && !S_AXI_ARREADY && SATELLITE_MODE
			&& word_ofs(S_AXI_ARADDR) == CLASS_REV_OFS) |=> S_AXI_RRESP == RESP_SLVERR;
	endproperty
	a_satellite_block: assert property (p_satellite_block)
		else $error("Class register read in satellite mode");

	property p_init_reset;
		@(posedge REF_CLK)
		$fell(RESET) |=> ctrl_r.initiator_enable == boot_host_r;
	endproperty
	a_init_reset: assert property (p_init_reset)
		else $error("Initiator enable wrong after reset");
endmodule : pcfg_regs

// ### dv/pcfg_pci_agent.sv
// ****************************************
// Far-side PCI agents: decode hits and initiator requests
// ****************************************
module pcfg_pci_agent (
	input wire logic clk,
	input wire logic run,
	output logic mem_hit,
	output logic io_hit,
	output logic special,
	output logic wr_req,
	output logic brd_req,
	output logic gnt_lost
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] r;
	initial begin
		{mem_hit, io_hit, special, wr_req, brd_req, gnt_lost} = 6'h00;
	end
	// Grant loss toggles rarely so runs reach past the latency count
	always @(posedge clk) begin
		r = $urandom;
		if (run) begin
			{mem_hit, io_hit, wr_req, brd_req} <= r[3:0];
			special <= (r[5:4] == 2'h0);
			if (r[8:6] == 3'h0) gnt_lost <= !gnt_lost;
		end else begin
			{mem_hit, io_hit, special, wr_req, brd_req, gnt_lost} <= 6'h00;
		end
	end
endmodule : pcfg_pci_agent

// ### dv/tb_pcfg_regs.sv
module tb_pcfg_regs;
	timeunit 1ns;
	timeprecision 100ps;
	import pcfg_pkg::*;
	logic REF_CLK = 0, RESET = 1, BOOT_MODE = 1, HOST_MODE = 1, SATELLITE_MODE = 0;
	logic INIT_LOAD = 0, run = 0, lvl_on = 0;
	logic [23:0] INIT_CLASS = 24'h000000;
	logic [7:0] INIT_REV = 8'h00;
	logic [6:0] INIT_HDR_TYPE = 7'h00;
	logic TGT_MEM_HIT, TGT_IO_HIT, TGT_SPECIAL_CYCLE, MST_WRITE_REQ, MST_BURST_READ_REQ;
	logic MST_GNT_LOST, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
	logic S_AXI_RREADY = 0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic CLAIM_MEM, CLAIM_IO, INITIATOR_ALLOWED, USE_MWI, BURST_READ_LINE, LAT_EXPIRED;
	logic [4:0] cmd_m = 5'h04;
	logic [7:0] lat_m = 8'h00, line_m = 8'h00;
	logic e_mem, e_io, e_ia, e_mwi, e_brl, e_lat;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int n_mismatch = 0, tests_run = 0, run_cnt = 0, cyc = 0;
	logic [31:0] rnd;

	pcfg_regs pcfg_regs_i (.REF_CLK, .RESET, .BOOT_MODE, .HOST_MODE, .SATELLITE_MODE,
		.INIT_LOAD, .INIT_CLASS, .INIT_REV, .INIT_HDR_TYPE, .TGT_MEM_HIT, .TGT_IO_HIT,
		.TGT_SPECIAL_CYCLE, .MST_WRITE_REQ, .MST_BURST_READ_REQ, .MST_GNT_LOST,
		.S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .CLAIM_MEM, .CLAIM_IO, .INITIATOR_ALLOWED, .USE_MWI,
		.BURST_READ_LINE, .LAT_EXPIRED);
	pcfg_pci_agent pcfg_pci_agent_i (.clk(REF_CLK), .run(run), .mem_hit(TGT_MEM_HIT),
		.io_hit(TGT_IO_HIT), .special(TGT_SPECIAL_CYCLE), .wr_req(MST_WRITE_REQ),
		.brd_req(MST_BURST_READ_REQ), .gnt_lost(MST_GNT_LOST));

	always #5 REF_CLK = !REF_CLK;

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test

	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test;
		end
	end

	// Outputs are one cycle behind their causes, so last edge's expectation is compared
	always @(posedge REF_CLK) begin
		if (!RESET && lvl_on) begin
			chk("CLAIM_MEM", e_mem, CLAIM_MEM);
			chk("CLAIM_IO", e_io, CLAIM_IO);
			chk("INITIATOR_ALLOWED", e_ia, INITIATOR_ALLOWED);
			chk("USE_MWI", e_mwi, USE_MWI);
			chk("BURST_READ_LINE", e_brl, BURST_READ_LINE);
			chk("LAT_EXPIRED", e_lat, LAT_EXPIRED);
		end
		if (!RESET && S_AXI_RVALID && S_AXI_RREADY) chk("read", rq.pop_front(),
			{S_AXI_RRESP, S_AXI_RDATA});
		if (!RESET && S_AXI_BVALID && S_AXI_BREADY) chk("BRESP", bq.pop_front(), S_AXI_BRESP);
		e_mem = TGT_MEM_HIT & !TGT_SPECIAL_CYCLE & cmd_m[1];
		e_io = TGT_IO_HIT & !TGT_SPECIAL_CYCLE & cmd_m[0];
		e_ia = cmd_m[2];
		e_mwi = MST_WRITE_REQ & cmd_m[2] & cmd_m[4];
		e_brl = MST_BURST_READ_REQ & (line_m != 8'h00);
		run_cnt = (MST_GNT_LOST && !RESET) ? run_cnt + 1 : 0;
		e_lat = (run_cnt >= lat_m + 1);
	end

	// ****************************************
	// AXI4-Lite master
	// ****************************************
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bit aw, w;
		@(posedge REF_CLK);
		bq.push_back(r);
		aw = 1;
		w = 1;
		S_AXI_AWADDR <= {16'h0000, a};
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		do begin
			@(posedge REF_CLK);
			if (aw && S_AXI_AWREADY) begin
				S_AXI_AWVALID <= 0;
				aw = 0;
			end
			if (w && S_AXI_WREADY) begin
				S_AXI_WVALID <= 0;
				w = 0;
			end
		end while (S_AXI_BVALID !== 1'h1);
		S_AXI_BREADY <= 0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge REF_CLK);
		rq.push_back({r, d});
		S_AXI_ARADDR <= {16'h0000, a};
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		do begin
			@(posedge REF_CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
		end while (S_AXI_RVALID !== 1'h1);
		S_AXI_RREADY <= 0;
	endtask : rd

	task automatic rst_dut(input logic b, input logic h);
		@(posedge REF_CLK);
		{RESET, BOOT_MODE, HOST_MODE} <= {1'h1, b, h};
		repeat (5) @(posedge REF_CLK);
		RESET <= 0;
		repeat (2) @(posedge REF_CLK);
		cmd_m = {2'h0, b & h, 2'h0};
		lat_m = 8'h00;
		line_m = 8'h00;
	endtask : rst_dut

	task automatic phase(input int n);
		run <= 1;
		lvl_on <= 1;
		repeat (n) @(posedge REF_CLK);
		run <= 0;
		repeat (3) @(posedge REF_CLK);
		lvl_on <= 0;
	endtask : phase

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h5628));
		rst_dut(1, 1);
		rd(CMD_STATUS_OFS, 32'h00000004, RESP_OKAY);
		rd(CLASS_REV_OFS, {CLASS_RST, REV_RST}, RESP_OKAY);
		rd(HDR_LAT_OFS, 32'h00000000, RESP_OKAY);
		phase(200);
		wr(CMD_STATUS_OFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		cmd_m = 5'h17;
		rd(CMD_STATUS_OFS, 32'h00000017, RESP_OKAY);
		wr(CLASS_REV_OFS, 32'h00000000, 4'hF, RESP_OKAY);
		rd(CLASS_REV_OFS, {CLASS_RST, REV_RST}, RESP_OKAY);
		wr(HDR_LAT_OFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		rd(HDR_LAT_OFS, 32'h0000FCFF, RESP_OKAY);
		wr(HDR_LAT_OFS, 32'h00000707, 4'h2, RESP_OKAY);
		lat_m = 8'h04;
		line_m = 8'hFF;
		rd(HDR_LAT_OFS, 32'h000004FF, RESP_OKAY);
		phase(600);
		wr(CMD_STATUS_OFS, 32'h00000013, 4'hF, RESP_OKAY);
		wr(HDR_LAT_OFS, 32'h00000000, 4'h1, RESP_OKAY);
		cmd_m = 5'h13;
		line_m = 8'h00;
		phase(300);
		rd(16'hD100, 32'h00000000, RESP_SLVERR);
		wr(16'hD100, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
		SATELLITE_MODE <= 1;
		rd(CLASS_REV_OFS, 32'h00000000, RESP_SLVERR);
		wr(CLASS_REV_OFS, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
		rd(HDR_LAT_OFS, 32'h00000400, RESP_OKAY);
		SATELLITE_MODE <= 0;
		rnd = $urandom;
		INIT_CLASS <= rnd[31:8];
		INIT_REV <= rnd[7:0];
		INIT_HDR_TYPE <= rnd[14:8];
		INIT_LOAD <= 1;
		@(posedge REF_CLK);
		INIT_LOAD <= 0;
		rd(CLASS_REV_OFS, rnd, RESP_OKAY);
		rd(HDR_LAT_OFS, {9'h000, rnd[14:8], 16'h0400}, RESP_OKAY);
		for (int m = 0; m < 3; m++) begin
			rst_dut(m[0], m[1]);
			rd(CMD_STATUS_OFS, 32'h00000000, RESP_OKAY);
			phase(50);
		end
		rd(CLASS_REV_OFS, {CLASS_RST, REV_RST}, RESP_OKAY);
		end_of_test;
	end
endmodule : tb_pcfg_regs
